//--- hw/meter_status_defs.svh
// Offsets, field positions, reset values and codes of the status and time bank.
`ifndef METER_STATUS_DEFS_SVH
`define METER_STATUS_DEFS_SVH

`define FC_READ            8'h03
`define FC_WRITE           8'h10

`define OFF_PROTECT        16'h101E
`define OFF_SEAL           16'h101F
`define OFF_ALARM_CLR      16'h1021
`define OFF_FLAGS          16'h102E
`define OFF_SPEED          16'h102F
`define OFF_PARITY         16'h1030
`define OFF_STATION        16'h1031
`define OFF_ALARM_IDX      16'h1032
`define OFF_EVENT_IDX      16'h1033
`define OFF_HOURS_HI       16'h1034
`define OFF_HOURS_LO       16'h1035
`define OFF_PRESENCE       16'h1036
`define OFF_PROTOCOL       16'h1038
`define OFF_DECADE         16'h1039
`define OFF_SHARP_CLR      16'h103A
`define OFF_PEAK_CLR       16'h103B
`define OFF_VALLEY_CLR     16'h103C
`define OFF_NORMAL_CLR     16'h103D
`define OFF_ALL_CLR        16'h103E
`define OFF_WEEKDAY        16'h103F
`define OFF_YEAR           16'h1040
`define OFF_MONTH          16'h1041
`define OFF_DAY            16'h1042
`define OFF_HOUR           16'h1043
`define OFF_MINUTE         16'h1044
`define OFF_SECOND         16'h1045

`define PROT_PORT1_BIT     0
`define PROT_PORT2_BIT     1
`define PROT_RUNCLR_BIT    2
`define PROT_PULSE_BIT     3
`define PROT_TARIFF_BIT    4
`define PROT_MAX           16'h001F

`define FLAG_ALARM_BIT     0
`define FLAG_EVENT_BIT     1

`define CLEAR_KEY          16'h000A
`define SEAL_KEY           16'h000A

`define SPEED_MIN          16'h12C0
`define SPEED_MAX          16'h9600
`define PARITY_MAX         16'h0003
`define PROTO_OTHER        2'h0
`define PROTO_BUILDING     2'h1
`define PROTO_MESH         2'h2
`define PROTO_MAX          16'h0002
`define WEEKDAY_MAX        16'h0006
`define YEAR_MIN           16'h07D0
`define YEAR_MAX           16'h0833
`define MONTH_MAX          16'h000C
`define DAY_MAX            16'h001F
`define HOUR_MAX           16'h0017
`define MINSEC_MAX         16'h003B
`define HOURS_MAX          32'h05F5E0FF

`define RST_SPEED          16'h9600
`define RST_PARITY         2'h3
`define RST_YEAR           12'h7D0
`define RST_MONTH          4'h1
`define RST_DAY            5'h01
`define RST_STATION        16'h0001

`endif

//--- hw/meter_status_pkg.sv
// Types of the status and time register bank.
package meter_status_pkg;

    typedef struct packed {
        logic        valid;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic        err;
        logic [15:0] rdata;
    } reg_rsp_t;

    typedef enum logic [2:0] {
        MOD_NONE     = 3'h0,
        MOD_SERIAL   = 3'h1,
        MOD_BUILDING = 3'h2,
        MOD_MESH     = 3'h3,
        MOD_ETHERNET = 3'h4,
        MOD_FIELDBUS = 3'h5
    } port2_module_t;

    typedef struct packed {
        logic [4:0]  protect;
        logic [15:0] seal;
        logic [15:0] speed;
        logic [1:0]  parity;
        logic [1:0]  proto;
        logic        decade;
        logic [1:0]  flags;
        logic [4:0]  alarm_idx;
        logic [4:0]  event_idx;
        logic [31:0] run_hours;
        logic [2:0]  weekday;
        logic [11:0] year;
        logic [3:0]  month;
        logic [4:0]  day;
        logic [4:0]  hour;
        logic [5:0]  minute;
        logic [5:0]  second;
        reg_rsp_t    rsp;
        logic        sealed;
        logic        clr_alarm;
        logic [4:0]  clr_tariff;
        logic        port2_en;
        logic [2:0]  mod_s1;
        logic [2:0]  mod_s2;
        logic        ok_s1;
        logic        ok_s2;
        logic [5:0]  pres_s1;
        logic [5:0]  pres_s2;
    } state_t;

endpackage : meter_status_pkg

//--- hw/meter_status_time_regs.sv
// Status, seal, second-port and calendar register bank of the meter.
`include "meter_status_defs.svh"

module meter_status_time_regs #(
    parameter int ALARM_GROUPS = 16,
    parameter int EVENT_GROUPS = 20
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_sys_rst,
    input  wire meter_status_pkg::reg_req_t    i_req,
    output      meter_status_pkg::reg_rsp_t    o_rsp,
    input  wire logic                          i_alarm_new,
    input  wire logic [4:0]                    i_alarm_group,
    input  wire logic                          i_event_new,
    input  wire logic [4:0]                    i_event_group,
    input  wire logic                          i_hour_tick,
    input  wire logic [5:0]                    i_module_present,
    input  wire logic [2:0]                    i_port2_module,
    input  wire logic                          i_port2_link_ok,
    output      logic                          o_seal_closed,
    output      logic [4:0]                    o_protected,
    output      logic                          o_clear_alarm_log,
    output      logic [4:0]                    o_clear_tariff,
    output      logic                          o_port2_enable,
    output      logic [15:0]                   o_port2_speed,
    output      logic [1:0]                    o_port2_parity,
    output      logic [1:0]                    o_port2_protocol,
    output      logic                          o_decade_download
);
    import meter_status_pkg::*;

    localparam state_t ST_RESET = '{speed:  `RST_SPEED,
                                    parity: `RST_PARITY,
                                    year:   `RST_YEAR,
                                    month:  `RST_MONTH,
                                    day:    `RST_DAY,
                                    default: '0};

    state_t st_reg;
    state_t st_next;
    logic   port2_locked;
    logic   is_write;

    function automatic logic addr_known(input logic [15:0] a);
        addr_known = (a >= `OFF_PROTECT && a <= `OFF_SECOND) &&
                     a != 16'h1020 && a != 16'h1037 &&
                     !(a >= 16'h1022 && a <= 16'h102D);
    endfunction : addr_known

    function automatic logic in_range(input logic [15:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = v >= lo && v <= hi;
    endfunction : in_range

    function automatic logic [15:0] read_word(input state_t s,
                                              input logic [15:0] a);
        read_word = 16'h0000;
        case (a)
            `OFF_PROTECT:   read_word = {11'h000, s.protect};
            `OFF_SEAL:      read_word = s.seal;
            `OFF_FLAGS:     read_word = {14'h0000, s.flags};
            `OFF_SPEED:     read_word = s.speed;
            `OFF_PARITY:    read_word = {14'h0000, s.parity};
            `OFF_STATION:   read_word = `RST_STATION;
            `OFF_ALARM_IDX: read_word = {11'h000, s.alarm_idx};
            `OFF_EVENT_IDX: read_word = {11'h000, s.event_idx};
            `OFF_HOURS_HI:  read_word = s.run_hours[31:16];
            `OFF_HOURS_LO:  read_word = s.run_hours[15:0];
            `OFF_PRESENCE:  read_word = {10'h000, s.pres_s2};
            `OFF_PROTOCOL:  read_word = {14'h0000, s.proto};
            `OFF_DECADE:    read_word = {15'h0000, s.decade};
            `OFF_WEEKDAY:   read_word = {13'h0000, s.weekday};
            `OFF_YEAR:      read_word = {4'h0, s.year};
            `OFF_MONTH:     read_word = {12'h000, s.month};
            `OFF_DAY:       read_word = {11'h000, s.day};
            `OFF_HOUR:      read_word = {11'h000, s.hour};
            `OFF_MINUTE:    read_word = {10'h000, s.minute};
            `OFF_SECOND:    read_word = {10'h000, s.second};
            default:        read_word = 16'h0000;
        endcase
    endfunction : read_word

    // A connected network adapter owns the port settings, and a closed seal
    // with the port item protected freezes them too.
    assign port2_locked =
        (st_reg.ok_s2 && (st_reg.mod_s2 == MOD_ETHERNET ||
                          st_reg.mod_s2 == MOD_FIELDBUS)) ||
        (st_reg.sealed && st_reg.protect[`PROT_PORT2_BIT]);
    assign is_write = i_req.valid && i_req.func == `FC_WRITE;

    always_comb begin
        st_next            = st_reg;
        st_next.rsp        = '0;
        st_next.clr_alarm  = 1'b0;
        st_next.clr_tariff = 5'h00;
        st_next.mod_s1     = i_port2_module;
        st_next.mod_s2     = st_reg.mod_s1;
        st_next.ok_s1      = i_port2_link_ok;
        st_next.ok_s2      = st_reg.ok_s1;
        st_next.pres_s1    = i_module_present;
        st_next.pres_s2    = st_reg.pres_s1;
        if (i_hour_tick && st_reg.run_hours != `HOURS_MAX) begin
            st_next.run_hours = st_reg.run_hours + 32'h0000_0001;
        end
        if (i_req.valid) begin
            st_next.rsp.valid = 1'b1;
            if (!addr_known(i_req.addr) ||
                (i_req.func != `FC_READ && i_req.func != `FC_WRITE)) begin
                st_next.rsp.err = 1'b1;
            end else if (i_req.func == `FC_READ) begin
                st_next.rsp.rdata = read_word(st_reg, i_req.addr);
            end else begin
                case (i_req.addr)
                    `OFF_PROTECT: begin
                        if (in_range(i_req.wdata, 16'h0000, `PROT_MAX))
                            st_next.protect = i_req.wdata[4:0];
                        else
                            st_next.rsp.err = 1'b1;
                    end
                    `OFF_SEAL: st_next.seal = i_req.wdata;
                    `OFF_ALARM_CLR:
                        st_next.clr_alarm =
                            i_req.wdata == `CLEAR_KEY;
                    `OFF_FLAGS:
                        st_next.flags = st_reg.flags &
                                        ~i_req.wdata[1:0];
                    `OFF_SPEED: begin
                        if (!port2_locked &&
                            in_range(i_req.wdata, `SPEED_MIN, `SPEED_MAX))
                            st_next.speed = i_req.wdata;
                        else
                            st_next.rsp.err = 1'b1;
                    end
                    `OFF_PARITY: begin
                        if (!port2_locked &&
                            in_range(i_req.wdata, 16'h0000, `PARITY_MAX))
                            st_next.parity = i_req.wdata[1:0];
                        else
                            st_next.rsp.err = 1'b1;
                    end
                    `OFF_PROTOCOL: begin
                        if (!port2_locked &&
                            in_range(i_req.wdata, 16'h0000, `PROTO_MAX))
                            st_next.proto = i_req.wdata[1:0];
                        else
                            st_next.rsp.err = 1'b1;
                    end
                    `OFF_DECADE: begin
                        if (in_range(i_req.wdata, 16'h0000, 16'h0001))
                            st_next.decade = i_req.wdata[0];
                        else
                            st_next.rsp.err = 1'b1;
                    end
                    `OFF_SHARP_CLR, `OFF_PEAK_CLR, `OFF_VALLEY_CLR,
                    `OFF_NORMAL_CLR, `OFF_ALL_CLR: begin
                        if (i_req.wdata == `CLEAR_KEY)
                            st_next.clr_tariff[3'(i_req.addr -
                                                  `OFF_SHARP_CLR)] = 1'b1;
                    end
                    `OFF_WEEKDAY: begin
                        if (in_range(i_req.wdata, 16'h0000, `WEEKDAY_MAX))
                            st_next.weekday = i_req.wdata[2:0];
                        else
                            st_next.rsp.err = 1'b1;
                    end
                    `OFF_YEAR: begin
                        if (in_range(i_req.wdata, `YEAR_MIN, `YEAR_MAX))
                            st_next.year = i_req.wdata[11:0];
                        else
                            st_next.rsp.err = 1'b1;
                    end
                    `OFF_MONTH: begin
                        if (in_range(i_req.wdata, 16'h0001, `MONTH_MAX))
                            st_next.month = i_req.wdata[3:0];
                        else
                            st_next.rsp.err = 1'b1;
                    end
                    `OFF_DAY: begin
                        if (in_range(i_req.wdata, 16'h0001, `DAY_MAX))
                            st_next.day = i_req.wdata[4:0];
                        else
                            st_next.rsp.err = 1'b1;
                    end
                    `OFF_HOUR: begin
                        if (in_range(i_req.wdata, 16'h0000, `HOUR_MAX))
                            st_next.hour = i_req.wdata[4:0];
                        else
                            st_next.rsp.err = 1'b1;
                    end
                    `OFF_MINUTE: begin
                        if (in_range(i_req.wdata, 16'h0000, `MINSEC_MAX))
                            st_next.minute = i_req.wdata[5:0];
                        else
                            st_next.rsp.err = 1'b1;
                    end
                    `OFF_SECOND: begin
                        if (in_range(i_req.wdata, 16'h0000, `MINSEC_MAX))
                            st_next.second = i_req.wdata[5:0];
                        else
                            st_next.rsp.err = 1'b1;
                    end
                    // Read-only words refuse a write without side effect.
                    default: st_next.rsp.err = 1'b1;
                endcase
            end
        end
        // New events are applied after the clear so that a set wins.
        if (i_alarm_new) begin
            st_next.flags[`FLAG_ALARM_BIT] = 1'b1;
            if (i_alarm_group != 5'h00 &&
                32'(i_alarm_group) <= ALARM_GROUPS)
                st_next.alarm_idx = i_alarm_group;
        end
        if (i_event_new) begin
            st_next.flags[`FLAG_EVENT_BIT] = 1'b1;
            if (i_event_group != 5'h00 &&
                32'(i_event_group) <= EVENT_GROUPS)
                st_next.event_idx = i_event_group;
        end
        st_next.sealed = st_next.seal == `SEAL_KEY;
        // Baud and parity needs of the modules are the configurer's duty;
        // hardware only checks that the module link is up and that protocol and module agree.
        unique case (st_next.proto)
            `PROTO_MESH:
                st_next.port2_en = st_reg.ok_s2 &&
                                   st_reg.mod_s2 == MOD_MESH;
            `PROTO_BUILDING:
                st_next.port2_en = st_reg.ok_s2 &&
                                   st_reg.mod_s2 == MOD_BUILDING;
            default:
                st_next.port2_en = st_reg.ok_s2 &&
                    (st_reg.mod_s2 == MOD_SERIAL ||
                     st_reg.mod_s2 == MOD_ETHERNET ||
                     st_reg.mod_s2 == MOD_FIELDBUS);
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rsp             = st_reg.rsp;
    assign o_seal_closed     = st_reg.sealed;
    assign o_protected       = st_reg.protect;
    assign o_clear_alarm_log = st_reg.clr_alarm;
    assign o_clear_tariff    = st_reg.clr_tariff;
    assign o_port2_enable    = st_reg.port2_en;
    assign o_port2_speed     = st_reg.speed;
    assign o_port2_parity    = st_reg.parity;
    assign o_port2_protocol  = st_reg.proto;
    assign o_decade_download = st_reg.decade;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_alarm_key;
        is_write && i_req.addr == `OFF_ALARM_CLR &&
        i_req.wdata == `CLEAR_KEY;
    endsequence

    sequence s_seal_key;
        is_write && i_req.addr == `OFF_SEAL && i_req.wdata == `SEAL_KEY;
    endsequence

    a_answer_next_cycle: assert property (
        i_req.valid |=> o_rsp.valid ##1 !o_rsp.valid || $past(i_req.valid))
        else $error("request not answered in the next cycle");

    a_bad_function: assert property (
        i_req.valid && i_req.func != `FC_READ && i_req.func != `FC_WRITE
        |=> o_rsp.valid && o_rsp.err)
        else $error("unknown function code not refused");

    a_seal_closes: assert property (
        s_seal_key |=> o_seal_closed)
        else $error("seal key written but seal not closed");

    a_alarm_clear_key: assert property (
        s_alarm_key |=> o_clear_alarm_log ##1 !o_clear_alarm_log ||
                        $past(i_req.valid))
        else $error("alarm record clear pulse wrong");

    a_alarm_clear_other: assert property (
        is_write && i_req.addr == `OFF_ALARM_CLR &&
        i_req.wdata != `CLEAR_KEY |=> !o_clear_alarm_log)
        else $error("alarm records cleared by a wrong value");

    a_flag_set_wins: assert property (
        i_alarm_new |=> st_reg.flags[`FLAG_ALARM_BIT])
        else $error("new alarm flag lost");

    a_alarm_index: assert property (
        i_alarm_new && i_alarm_group != 5'h00 && i_alarm_group <= 5'h10
        |=> st_reg.alarm_idx == $past(i_alarm_group))
        else $error("alarm group index not stored");

    a_event_index: assert property (
        i_event_new && i_event_group != 5'h00 && i_event_group <= 5'h14
        |=> st_reg.event_idx == $past(i_event_group))
        else $error("event group index not stored");

    a_port2_gated: assert property (
        o_port2_enable |-> $past(st_reg.ok_s2))
        else $error("second port enabled without a linked module");

    a_port2_locked: assert property (
        is_write && port2_locked && i_req.addr == `OFF_SPEED
        |=> o_rsp.err && $stable(o_port2_speed))
        else $error("locked second port speed was changed");

    a_parity_range: assert property (
        is_write && i_req.addr == `OFF_PARITY && i_req.wdata > `PARITY_MAX
        |=> o_rsp.err && $stable(o_port2_parity))
        else $error("out of range parity accepted");

    a_month_range: assert property (
        is_write && i_req.addr == `OFF_MONTH &&
        (i_req.wdata == 16'h0000 || i_req.wdata > `MONTH_MAX)
        |=> o_rsp.err)
        else $error("out of range month accepted");

    a_tariff_clear_other: assert property (
        is_write && i_req.addr >= `OFF_SHARP_CLR &&
        i_req.addr <= `OFF_ALL_CLR && i_req.wdata != `CLEAR_KEY
        |=> o_clear_tariff == 5'h00)
        else $error("tariff demand cleared by a wrong value");

    a_seal_opens: assert property (
        is_write && i_req.addr == `OFF_SEAL && i_req.wdata != `SEAL_KEY
        |=> !o_seal_closed)
        else $error("seal shown closed without the key");

    a_event_flag_set: assert property (
        i_event_new |=> st_reg.flags[`FLAG_EVENT_BIT])
        else $error("new event flag lost");

    a_protocol_locked: assert property (
        is_write && port2_locked && i_req.addr == `OFF_PROTOCOL
        |=> o_rsp.err && $stable(o_port2_protocol))
        else $error("locked second port protocol was changed");

    a_parity_locked: assert property (
        is_write && port2_locked && i_req.addr == `OFF_PARITY
        |=> o_rsp.err && $stable(o_port2_parity))
        else $error("locked second port parity was changed");

    a_protect_stored: assert property (
        is_write && i_req.addr == `OFF_PROTECT && i_req.wdata <= `PROT_MAX
        |=> o_protected == $past(i_req.wdata[4:0]))
        else $error("protection selection not stored");

    a_year_range: assert property (
        is_write && i_req.addr == `OFF_YEAR &&
        (i_req.wdata < `YEAR_MIN || i_req.wdata > `YEAR_MAX)
        |=> o_rsp.err && $stable(st_reg.year))
        else $error("out of range year accepted");

endmodule : meter_status_time_regs

//--- verification/poll_master.sv
// Polling controller model: it issues one register word per access.
module poll_master (
    input  wire logic                       i_clk,
    input  wire meter_status_pkg::reg_rsp_t i_rsp,
    output      meter_status_pkg::reg_req_t o_req
);
    timeunit 1ns;
    timeprecision 1ns;
    import meter_status_pkg::*;
    initial o_req = '0;
    // Idle lines flip, so a stale word can never pass for a live request.
    task automatic access(input logic [7:0] f, input logic [15:0] a,
                          input logic [15:0] d, output reg_rsp_t rsp);
        @(posedge i_clk);
        #1 o_req = '{1'b1, f, a, d};
        @(posedge i_clk);
        #1 rsp = i_rsp;
        o_req = '{1'b0, ~f, ~a, ~d};
    endtask : access
endmodule : poll_master

//--- verification/test_meter_status_time_regs.sv
// Self-checking bench of the status, seal, second-port and calendar bank.
`include "meter_status_defs.svh"
module test_meter_status_time_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import meter_status_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    reg_req_t    req;
    reg_rsp_t    rsp, r;
    logic        alarm_new, event_new, hour_tick, link_ok, sealed, clr_a;
    logic        p2_en, decade;
    logic [4:0]  alarm_grp, event_grp, prot, clr_t;
    logic [5:0]  present;
    logic [2:0]  module_sel;
    logic [15:0] p2_speed, v;
    logic [1:0]  p2_parity, p2_proto;
    logic [31:0] tmp;
    logic [15:0] cal [7];
    int          n_fail = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          seed;
    localparam logic [15:0] CMIN [7] = '{16'h0, 16'h7D0, 16'h1, 16'h1,
                                         16'h0, 16'h0, 16'h0};
    localparam logic [15:0] CMAX [7] = '{16'h6, 16'h833, 16'hC, 16'h1F,
                                         16'h17, 16'h3B, 16'h3B};
    localparam logic [2:0]  MATCH [3] = '{3'h1, 3'h2, 3'h3};

    meter_status_time_regs u_meter_status_time_regs (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req), .o_rsp(rsp),
        .i_alarm_new(alarm_new), .i_alarm_group(alarm_grp),
        .i_event_new(event_new), .i_event_group(event_grp),
        .i_hour_tick(hour_tick), .i_module_present(present),
        .i_port2_module(module_sel), .i_port2_link_ok(link_ok),
        .o_seal_closed(sealed), .o_protected(prot),
        .o_clear_alarm_log(clr_a), .o_clear_tariff(clr_t),
        .o_port2_enable(p2_en), .o_port2_speed(p2_speed),
        .o_port2_parity(p2_parity), .o_port2_protocol(p2_proto),
        .o_decade_download(decade));
    poll_master u_poll_master (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));

    always #50 i_clk = ~i_clk;

    function automatic logic cal_err(int f, logic [15:0] x);
        return x < CMIN[f] || x > CMAX[f];
    endfunction : cal_err

    function automatic logic [5:0] clr_exp(int i, logic [15:0] key);
        if (key != `CLEAR_KEY) return 6'h00;
        return (i == 0) ? 6'h20 : 6'(1 << (i - 1));
    endfunction : clr_exp

    task automatic end_sim();
        $display("fails=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic [7:0] f, input logic [15:0] a,
                        input logic [15:0] d, input logic e,
                        input logic [15:0] x);
        u_poll_master.access(f, a, d, r);
        chk(16'({r.valid, r.err}), 16'({1'b1, e}));
        if (f == `FC_READ && !e) chk(r.rdata, x);
    endtask : xfer

    task automatic wr(input logic [15:0] a, input logic [15:0] d, logic e);
        xfer(`FC_WRITE, a, d, e, 16'h0);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] x);
        xfer(`FC_READ, a, 16'h0, 1'b0, x);
    endtask : rd

    task automatic wait_n(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : wait_n

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        seed = 90792;
        tmp = $random(seed);
        {alarm_new, event_new, hour_tick, link_ok} = 4'h0;
        {alarm_grp, event_grp, module_sel} = 13'h0;
        present = tmp[5:0];
        cal = '{16'h0, 16'h7D0, 16'h1, 16'h1, 16'h0, 16'h0, 16'h0};
        wait_n(16);
        i_sys_rst = 1'b0;
        rd(`OFF_SPEED, `RST_SPEED);
        rd(`OFF_PARITY, 16'h0003);
        rd(`OFF_ALARM_IDX, 16'h0);
        rd(`OFF_EVENT_IDX, 16'h0);
        rd(`OFF_PRESENCE, 16'(tmp[5:0]));
        xfer(8'h06, `OFF_SEAL, 16'h0, 1'b1, 16'h0);
        xfer(`FC_READ, 16'h1020, 16'h0, 1'b1, 16'h0);
        chk(16'(r.err), 16'h1);
        wr(`OFF_STATION, 16'h0002, 1'b1);
        v = 16'($random(seed)) & `PROT_MAX;
        wr(`OFF_PROTECT, v, 1'b0);
        wr(`OFF_PROTECT, 16'h0020, 1'b1);
        chk(16'(prot), v);
        wr(`OFF_DECADE, 16'h0001, 1'b0);
        wr(`OFF_DECADE, 16'h0002, 1'b1);
        chk(16'(decade), 16'h1);
        for (int i = 0; i < 8; i++) begin
            v = i[0] ? `SEAL_KEY : 16'($random(seed)) & 16'h00FF;
            wr(`OFF_SEAL, v, 1'b0);
            chk(16'(sealed), 16'(v == `SEAL_KEY));
        end
        wr(`OFF_SEAL, 16'h0000, 1'b0);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? `OFF_ALARM_CLR : `OFF_SHARP_CLR + 16'(i - 1);
            wr(v, `CLEAR_KEY, 1'b0);
            chk(16'({clr_a, clr_t}), 16'(clr_exp(i, `CLEAR_KEY)));
            wait_n(1);
            chk(16'({clr_a, clr_t}), 16'h0);
            wr(v, 16'h000B, 1'b0);
            chk(16'({clr_a, clr_t}), 16'(clr_exp(i, 16'h000B)));
        end
        tmp = $random(seed);
        @(posedge i_clk);
        #1 {alarm_new, event_new, hour_tick} = 3'h7;
        alarm_grp = 5'(tmp[3:0]) + 5'h1;
        event_grp = 5'd20;
        @(posedge i_clk);
        #1 {alarm_new, event_new, hour_tick} = 3'h0;
        rd(`OFF_FLAGS, 16'h0003);
        rd(`OFF_ALARM_IDX, 16'(alarm_grp));
        rd(`OFF_EVENT_IDX, 16'd20);
        rd(`OFF_HOURS_LO, 16'h0001);
        wr(`OFF_FLAGS, 16'h0003, 1'b0);
        rd(`OFF_FLAGS, 16'h0000);
        for (int p = 0; p < 5; p++) begin
            wr(`OFF_PARITY, 16'(p), p > 3);
            if (p < 4) chk(16'(p2_parity), 16'(p));
        end
        wr(`OFF_SPEED, 16'h2580, 1'b0);
        for (int p = 0; p < 3; p++) begin
            wr(`OFF_PROTOCOL, 16'(p), 1'b0);
            {module_sel, link_ok} = {MATCH[p], 1'b1};
            wait_n(5);
            chk(16'({p2_en, p2_proto}), 16'({1'b1, 2'(p)}));
            module_sel = MATCH[(p + 1) % 3];
            wait_n(5);
            chk(16'(p2_en), 16'h0);
        end
        wr(`OFF_PROTOCOL, 16'h0003, 1'b1);
        {module_sel, link_ok} = {3'h4, 1'b0};
        wr(`OFF_PROTOCOL, 16'h0000, 1'b0);
        wr(`OFF_SPEED, 16'h9600, 1'b0);
        link_ok = 1'b1;
        wait_n(5);
        wr(`OFF_SPEED, `SPEED_MIN, 1'b1);
        wr(`OFF_PARITY, 16'h0000, 1'b1);
        wr(`OFF_PROTOCOL, 16'h0001, 1'b1);
        chk(p2_speed, 16'h9600);
        for (int f = 0; f < 7; f++) begin
            for (int k = 0; k < 5; k++) begin
                tmp = $random(seed);
                v = (k == 0) ? CMIN[f] : (k == 1) ? CMAX[f] :
                    (k == 2) ? CMAX[f] + 16'h1 : (k == 3) ? CMIN[f] - 16'h1 :
                    CMIN[f] + 16'(tmp % (CMAX[f] - CMIN[f] + 1));
                wr(`OFF_WEEKDAY + 16'(f), v, cal_err(f, v));
                if (!cal_err(f, v)) cal[f] = v;
                rd(`OFF_WEEKDAY + 16'(f), cal[f]);
            end
        end
        end_sim();
    end
endmodule : test_meter_status_time_regs
